// >>> sbr_consts.svh
// constants for the synchronous burst read configuration block
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH

// read configuration field positions
`define SBR_READ_MODE_POS      15
`define SBR_LATENCY_MSB        13
`define SBR_LATENCY_LSB        11
`define SBR_WAIT_POL_POS       10
`define SBR_HOLD_POS           9
`define SBR_WAIT_TIMING_POS    8
`define SBR_BURST_ORDER_POS    7
`define SBR_ACTIVE_EDGE_POS    6
`define SBR_PIN_FUNC_POS       4
`define SBR_WRAP_POS           3
`define SBR_LENGTH_MSB         2
`define SBR_LENGTH_LSB         0

// reset value of the read configuration register
`define SBR_CFG_RESET          16'h3ddf

// burst length codes
`define SBR_LEN_4              3'h1
`define SBR_LEN_8              3'h2
`define SBR_LEN_16             3'h3
`define SBR_LEN_CONT           3'h7

// latency code limits
`define SBR_LAT_MIN            3'h2
`define SBR_LAT_MAX            3'h7

// internal configuration time after reset, in ns, and in system clocks
`define SBR_INIT_TIME_NS       640
`define SBR_CLK_PERIOD_NS      10
`define SBR_INIT_CYCLES        (`SBR_INIT_TIME_NS / `SBR_CLK_PERIOD_NS)

`endif

// >>> sbr_pkg.sv
// types shared by the synchronous burst read block
package sbr_pkg;

   // read configuration register layout
   typedef struct packed {
      logic       read_mode_bit;             // 0 synchronous
      logic       reserved_bit_upper;        // kept as written
      logic [2:0] first_data_latency_field;  // binary cycle count
      logic       wait_polarity_bit;         // 1 active high
      logic       data_hold_cycles_bit;      // 1 two-cycle hold
      logic       wait_timing_bit;           // 1 early wait
      logic       burst_order_bit;           // 1 sequential
      logic       active_edge_bit;           // 1 rising edge
      logic       reserved_bit_lower;        // kept as written
      logic       pin_function_bit;          // 1 ready function
      logic       wrap_select_bit;           // 1 no wrap
      logic [2:0] burst_length_field;        // length code
   } sbr_cfg_s;

   // burst sequencer states
   typedef enum logic [1:0] {
      SBR_IDLE,
      SBR_LATENCY,
      SBR_STREAM,
      SBR_END
   } sbr_state_e;

endpackage : sbr_pkg

// >>> sbr_pin_sync.sv
// two-stage synchroniser with an edge-detect stage for pin inputs
module sbr_pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             srst_i,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_i,
   // synchronised value and its previous sample
   output logic [WIDTH-1:0]      sync_o,
   output logic [WIDTH-1:0]      prev_o
);

   logic [WIDTH-1:0] meta;  // first stage, read only by the second
   logic [WIDTH-1:0] sync;  // second stage
   logic [WIDTH-1:0] prev;  // one more sample for edge detection

   initial begin
      if (WIDTH < 1)
         $error("sbr_pin_sync needs WIDTH of at least 1");
   end

   // three flops per bit, all reset to zero
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end
      else
      begin
         meta <= pin_i;
         sync <= meta;
         prev <= sync;
      end
   end

   assign sync_o = sync;
   assign prev_o = prev;

endmodule // sbr_pin_sync

// >>> sbr_burst_ctrl.sv
// synchronous burst read engine steered by the read configuration register
`include "sbr_consts.svh"

module sbr_burst_ctrl
   import sbr_pkg::*;
#(
   parameter int AW = 23,   // word address width
   parameter int DW = 16    // data width
) (
   // system clock and reset
   input  wire logic          clk_sys_i,
   input  wire logic          srst_i,
   // host pins
   input  wire logic          link_clk_i,   // burst clock from the host
   input  wire logic          latch_n_i,    // latch enable, active low
   input  wire logic          chip_n_i,     // chip enable, active low
   input  wire logic          oe_n_i,       // output enable, active low
   input  wire logic          reset_pulse_pin_n_i, // reset pulse, active low
   input  wire logic [AW-1:0] addr_i,       // burst start address
   output logic [DW-1:0]      data_o,       // data pins
   output logic               data_oe_o,    // data pins driven
   // ready/wait pin as three signals
   input  wire logic          rdy_wait_i,
   output logic               rdy_wait_o,
   output logic               rdy_wait_oe_o,
   // configuration command port
   input  wire logic          cfg_wr_i,     // write strobe
   input  wire logic [15:0]   cfg_data_i,   // new configuration
   output logic [15:0]        cfg_o,        // configuration readback
   output logic               init_done_o,  // internal configuration finished
   output logic               first_address_latch_sequence_restart_o, // latching sequence restart pulse
   // array read port
   output logic [AW-1:0]      mem_addr_o,
   input  wire logic [DW-1:0] mem_data_i
);

   localparam int SW = AW + 6;  // synchronised pin vector width

   initial begin
      if (AW < 5 || DW < 1)
         $error("sbr_burst_ctrl needs AW of at least 5 and DW of at least 1");
   end

   // burst length code to word count minus one, 0 for continuous
   function automatic logic [3:0] len_mask(input logic [2:0] code);
      case (code)
         `SBR_LEN_4:  len_mask = 4'h3;
         `SBR_LEN_8:  len_mask = 4'h7;
         `SBR_LEN_16: len_mask = 4'hf;
         default:     len_mask = 4'h0;
      endcase
   endfunction

   // pin synchroniser
   logic [SW-1:0] pin_s;  // synchronised pins
   logic [SW-1:0] pin_p;  // previous samples

   sbr_pin_sync #(
      .WIDTH (SW)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .pin_i     ({link_clk_i, latch_n_i, chip_n_i, oe_n_i, rdy_wait_i,
                   reset_pulse_pin_n_i, addr_i}),
      .sync_o    (pin_s),
      .prev_o    (pin_p)
   );

   logic          k_s, k_p, le_n, ce_n, g_n, rw_s, rw_p, rp_n;
   logic [AW-1:0] addr_s;
   assign {k_s, le_n, ce_n, g_n, rw_s, rp_n, addr_s} = pin_s;
   assign k_p  = pin_p[SW-1];
   assign rw_p = pin_p[AW+1];

   // configuration and init state
   sbr_cfg_s      cfg, next_cfg;           // read configuration
   logic [15:0]   init_cnt, next_init_cnt; // configuration countdown
   logic [1:0]    rdy_seq, next_rdy_seq;   // ready pin pulse tracker
   logic          first_address_latch_sequence, next_first_address_latch_sequence;         // restart pulse

   logic [2:0]    lat;     // latency code in use
   logic [3:0]    mask;    // wrap mask, 0 for continuous
   logic          cont;    // continuous burst
   logic          act_edge;
   assign lat  = cfg.first_data_latency_field;
   assign mask = len_mask(cfg.burst_length_field);
   assign cont = (mask == 4'h0);
   // falling or rising link clock edge is active
   assign act_edge = cfg.active_edge_bit ? (k_s & ~k_p) : (~k_s & k_p);

   // configuration, init countdown and ready pulse tracking
   always_comb
   begin
      next_cfg      = cfg;
      next_init_cnt = init_cnt;
      next_rdy_seq  = rdy_seq;
      next_first_address_latch_sequence     = 1'b0;
      if (!rp_n)
      begin
         // reset pulse reloads defaults and restarts configuration
         next_cfg      = sbr_cfg_s'(`SBR_CFG_RESET);
         next_init_cnt = 16'(`SBR_INIT_CYCLES);
         next_rdy_seq  = 2'h0;
      end
      else
      begin
         if (init_cnt != 16'h0)
            next_init_cnt = init_cnt - 16'h1;
         if (cfg_wr_i)
         begin
            next_cfg = sbr_cfg_s'(cfg_data_i);
            // only sequential ordering exists
            next_cfg.burst_order_bit = 1'b1;
         end
         // high, low, high on the released ready pin restarts latching
         if (cfg.pin_function_bit && init_cnt == 16'h0)
         begin
            case (rdy_seq)
               2'h0:    if (rw_s) next_rdy_seq = 2'h1;
               2'h1:    if (!rw_s) next_rdy_seq = 2'h2;
               2'h2:
                  if (rw_s)
                  begin
                     next_rdy_seq = 2'h1;
                     next_first_address_latch_sequence    = 1'b1;
                  end
               default: next_rdy_seq = 2'h0;
            endcase
         end
         else
            next_rdy_seq = 2'h0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         cfg      <= sbr_cfg_s'(`SBR_CFG_RESET);
         init_cnt <= 16'(`SBR_INIT_CYCLES);
         rdy_seq  <= 2'h0;
         first_address_latch_sequence     <= 1'b0;
      end
      else
      begin
         cfg      <= next_cfg;
         init_cnt <= next_init_cnt;
         rdy_seq  <= next_rdy_seq;
         first_address_latch_sequence     <= next_first_address_latch_sequence;
      end
   end

   // burst sequencer, running one data slot ahead of the pins
   sbr_state_e    state, next_state;
   logic [2:0]    lat_cnt, next_lat_cnt;   // active edges since latch
   logic          phase, next_phase;       // second edge of a held slot
   logic [AW-1:0] word, next_word;         // next word to fetch
   logic [1:0]    start_ofs, next_start_ofs;
   logic [1:0]    bw_cnt, next_bw_cnt;     // boundary waits left
   logic          bw_used, next_bw_used;   // boundary wait already spent
   logic [4:0]    left, next_left;         // words left in a fixed burst
   logic          seq_valid, next_seq_valid; // slot ahead carries data
   logic [AW-1:0] seq_addr, next_seq_addr;
   logic          pipe_valid, next_pipe_valid; // slot on the pins
   logic [DW-1:0] pipe_data, next_pipe_data;
   logic          tick;                    // a data slot ends here
   logic          wrap_on;

   // continuous bursts ignore the wrap bit
   assign wrap_on = ~cfg.wrap_select_bit & ~cont;
   // a slot spans one or two active edges
   assign tick = act_edge & (~cfg.data_hold_cycles_bit | phase);

   always_comb
   begin
      next_state      = state;
      next_lat_cnt    = lat_cnt;
      next_phase      = phase;
      next_word       = word;
      next_start_ofs  = start_ofs;
      next_bw_cnt     = bw_cnt;
      next_bw_used    = bw_used;
      next_left       = left;
      next_seq_valid  = seq_valid;
      next_seq_addr   = seq_addr;
      next_pipe_valid = pipe_valid;
      next_pipe_data  = pipe_data;
      if (ce_n || cfg.read_mode_bit || init_cnt != 16'h0)
      begin
         next_state      = SBR_IDLE;
         next_seq_valid  = 1'b0;
         next_pipe_valid = 1'b0;
      end
      else
      begin
         if (state != SBR_IDLE && state != SBR_LATENCY && act_edge)
            next_phase = ~phase;
         if (tick && state != SBR_IDLE && state != SBR_LATENCY)
         begin
            // the slot ahead moves onto the pins
            next_pipe_valid = seq_valid;
            next_pipe_data  = mem_data_i;
         end
         case (state)
            SBR_IDLE:
               // both enables low: this active edge takes the address
               if (act_edge && !le_n)
               begin
                  next_state     = SBR_LATENCY;
                  next_lat_cnt   = 3'h1;
                  next_word      = addr_s;
                  next_start_ofs = addr_s[1:0];
                  next_bw_used   = 1'b0;
                  next_bw_cnt    = 2'h0;
                  next_left      = 5'({1'b0, mask}) + 5'h1;
               end
            SBR_LATENCY:
               if (act_edge)
               begin
                  next_lat_cnt = lat_cnt + 3'h1;
                  // fetch the first word one slot before it is due
                  // lat_cnt counts active edges since the latch edge
                  if (lat_cnt >= lat - 3'h1)
                  begin
                     next_state     = SBR_STREAM;
                     next_phase     = 1'b0;
                     next_seq_valid = 1'b1;
                     next_seq_addr  = word;
                     next_word      = word + AW'(1);
                     next_left      = left - 5'h1;
                     if (wrap_on)
                     begin
                        // no carry out of the aligned block
                        next_word[AW-1:4] = word[AW-1:4];
                        next_word[3:0] = (word[3:0] & ~mask) | ((word[3:0] + 4'h1) & mask);
                     end
                     else if (word[3:0] == 4'hf && start_ofs != 2'h0 && !bw_used)
                     begin
                        next_bw_cnt  = start_ofs;
                        next_bw_used = 1'b1;
                     end
                  end
               end
            SBR_STREAM:
               if (tick)
               begin
                  if (!cont && left == 5'h0)
                  begin
                     // fixed burst exhausted: wait stays asserted
                     next_state     = SBR_END;
                     next_seq_valid = 1'b0;
                  end
                  else if (bw_cnt != 2'h0)
                  begin
                     next_bw_cnt    = bw_cnt - 2'h1;
                     next_seq_valid = 1'b0;
                  end
                  else
                  begin
                     next_seq_valid = 1'b1;
                     next_seq_addr  = word;
                     next_word      = word + AW'(1);
                     next_left      = left - 5'h1;
                     if (wrap_on)
                     begin
                        // no carry out of the aligned block
                        next_word[AW-1:4] = word[AW-1:4];
                        next_word[3:0] = (word[3:0] & ~mask) | ((word[3:0] + 4'h1) & mask);
                     end
                     else if (word[3:0] == 4'hf && start_ofs != 2'h0 && !bw_used)
                     begin
                        // the first 16-word crossing only
                        next_bw_cnt  = start_ofs;
                        next_bw_used = 1'b1;
                     end
                  end
               end
            SBR_END:
               next_seq_valid = 1'b0;
            default:
               next_state = SBR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         state      <= SBR_IDLE;
         lat_cnt    <= 3'h0;
         phase      <= 1'b0;
         word       <= '0;
         start_ofs  <= 2'h0;
         bw_cnt     <= 2'h0;
         bw_used    <= 1'b0;
         left       <= 5'h0;
         seq_valid  <= 1'b0;
         seq_addr   <= '0;
         pipe_valid <= 1'b0;
         pipe_data  <= '0;
      end
      else
      begin
         state      <= next_state;
         lat_cnt    <= next_lat_cnt;
         phase      <= next_phase;
         word       <= next_word;
         start_ofs  <= next_start_ofs;
         bw_cnt     <= next_bw_cnt;
         bw_used    <= next_bw_used;
         left       <= next_left;
         seq_valid  <= next_seq_valid;
         seq_addr   <= next_seq_addr;
         pipe_valid <= next_pipe_valid;
         pipe_data  <= next_pipe_data;
      end
   end

   // pin drivers
   logic wait_act;  // wait asserted, before polarity
   logic sync_rd;   // synchronous read selected and enabled
   assign sync_rd = ~ce_n & ~g_n & ~cfg.read_mode_bit;
   // early timing shows the slot ahead, normal shows the slot on the pins
   assign wait_act = cfg.wait_timing_bit ? ~seq_valid : ~pipe_valid;

   always_comb
   begin
      if (cfg.pin_function_bit)
      begin
         // ready function: pulled low during configuration, else released
         rdy_wait_o    = 1'b0;
         rdy_wait_oe_o = (init_cnt != 16'h0);
      end
      else
      begin
         // wait function, driven only during synchronous reads
         rdy_wait_o    = cfg.wait_polarity_bit ? wait_act : ~wait_act;
         rdy_wait_oe_o = sync_rd;
      end
   end

   assign data_o         = pipe_data;
   assign data_oe_o      = sync_rd;
   assign mem_addr_o     = seq_addr;
   assign cfg_o          = 16'(cfg);
   assign init_done_o    = (init_cnt == 16'h0);
   assign first_address_latch_sequence_restart_o = first_address_latch_sequence;

endmodule // sbr_burst_ctrl

// >>> sbr_burst_monitor.sv
// assertion checker for the burst read engine ports
module sbr_burst_monitor
   import sbr_pkg::*;
#(
   parameter int AW = 23,
   parameter int DW = 16
) (
   // clock and reset
   input wire logic          clk_sys_i,
   input wire logic          srst_i,
   // host pins
   input wire logic          link_clk_i,
   input wire logic          latch_n_i,
   input wire logic          chip_n_i,
   input wire logic          oe_n_i,
   input wire logic          reset_pulse_pin_n_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] data_o,
   input wire logic          data_oe_o,
   // ready/wait pin
   input wire logic          rdy_wait_i,
   input wire logic          rdy_wait_o,
   input wire logic          rdy_wait_oe_o,
   // configuration port
   input wire logic          cfg_wr_i,
   input wire logic [15:0]   cfg_data_i,
   input wire logic [15:0]   cfg_o,
   input wire logic          init_done_o,
   input wire logic          first_address_latch_sequence_restart_o,
   // array port
   input wire logic [AW-1:0] mem_addr_o,
   input wire logic [DW-1:0] mem_data_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // every check runs on the system clock and sleeps in reset
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   // reset pulse pin low long enough to pass the synchroniser
   sequence s_rp_held;
      !reset_pulse_pin_n_i [*6];
   endsequence
   // countdown quiet for 60 clocks, then done within 8 more
   sequence s_init_wait;
      (!init_done_o throughout (##60 1'b1)) ##[1:8] init_done_o;
   endsequence

   property p_reset_cfg;
      $fell(srst_i) |-> cfg_o == 16'h3ddf;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg)
      else $error("configuration not at default after reset");
   property p_init_time;
      $fell(srst_i) |-> s_init_wait;
   endproperty
   a_init_time: assert property (p_init_time)
      else $error("internal configuration time wrong");
   property p_ready_hold;
      !init_done_o && $past(init_done_o) == 1'b0 && cfg_o[4] |-> rdy_wait_oe_o && !rdy_wait_o;
   endproperty
   a_ready_hold: assert property (p_ready_hold)
      else $error("ready pin not held low during configuration");
   property p_ready_free;
      init_done_o && $past(init_done_o) && cfg_o[4] && $past(cfg_o[4]) |-> !rdy_wait_oe_o;
   endproperty
   a_ready_free: assert property (p_ready_free)
      else $error("ready pin still driven after configuration");
   property p_rp_reload;
      s_rp_held |-> cfg_o == 16'h3ddf && !init_done_o;
   endproperty
   a_rp_reload: assert property (p_rp_reload)
      else $error("reset pulse did not reload configuration");
   property p_write;
      cfg_wr_i && init_done_o && reset_pulse_pin_n_i ##1 init_done_o
         |-> cfg_o == ($past(cfg_data_i) | 16'h0080);
   endproperty
   a_write: assert property (p_write)
      else $error("configuration write not taken");
   property p_order;
      cfg_o[7] == 1'b1;
   endproperty
   a_order: assert property (p_order)
      else $error("burst order not sequential");
   property p_first_address_latch_sequence_pulse;
      first_address_latch_sequence_restart_o |-> cfg_o[4] ##1 !first_address_latch_sequence_restart_o;
   endproperty
   a_first_address_latch_sequence_pulse: assert property (p_first_address_latch_sequence_pulse)
      else $error("restart pulse malformed");
   property p_data_off;
      chip_n_i [*5] |-> !data_oe_o;
   endproperty
   a_data_off: assert property (p_data_off)
      else $error("data driven while deselected");
endmodule // sbr_burst_monitor

// attach the checker to every burst engine
bind sbr_burst_ctrl sbr_burst_monitor #(
   .AW(AW),
   .DW(DW)
) u_mon (
   .clk_sys_i, .srst_i, .link_clk_i, .latch_n_i, .chip_n_i, .oe_n_i,
   .reset_pulse_pin_n_i, .addr_i, .data_o, .data_oe_o, .rdy_wait_i,
   .rdy_wait_o, .rdy_wait_oe_o, .cfg_wr_i, .cfg_data_i, .cfg_o,
   .init_done_o, .first_address_latch_sequence_restart_o, .mem_addr_o, .mem_data_i
);

// >>> sbr_host_model.sv
// host model: latches an address, clocks a burst, samples each slot
module sbr_host_model
   import sbr_pkg::*;
(
   // host pins
   output logic        link_clk_o,
   output logic        latch_n_o,
   output logic        chip_n_o,
   output logic        oe_n_o,
   output logic [22:0] addr_o,
   // data and wait pin seen by the host
   input  wire logic [15:0] data_i,
   input  wire logic   rdy_wait_i,
   // sampling settings and slot reports
   input  wire logic   rise_i,     // active edge is rising
   input  wire logic   pol_i,      // asserted wait level
   input  wire logic   early_i,    // wait leads its slot by one
   input  wire logic   two_i,      // slots span two edges
   output logic        slot_stb_o,
   output logic [16:0] slot_o      // wait flag, then word
);
   timeunit 1ns;
   timeprecision 1ps;

   logic prev_w;                   // wait seen one sample earlier
   logic w;                        // wait seen at this sample
   logic w2;                       // wait seen two samples earlier

   // idle pins; address shows a pattern, not a stale value
   initial
   begin
      link_clk_o = 1'b0;
      latch_n_o = 1'b1;
      chip_n_o = 1'b1;
      oe_n_o = 1'b1;
      addr_o = 23'h2aaaaa;
      slot_stb_o = 1'b0;
      slot_o = 17'h0;
   end

   // one frame: latch edge plus n sampled edges; clock still outside
   task automatic burst(input logic [22:0] start, input int n);
      link_clk_o = !rise_i;
      addr_o = start;
      chip_n_o = 1'b0;
      latch_n_o = 1'b0;
      oe_n_o = 1'b0;
      prev_w = 1'b1;
      w2 = 1'b1;
      #47;
      for (int k = 0; k <= n; k++)
      begin
         if (k > 0)
         begin
            w = (rdy_wait_i == pol_i);
            // early wait leads by one data slot, two samples when held
            slot_o = (early_i ? (two_i ? w2 : prev_w) : w) ? 17'h10000 : {1'b0, data_i};
            w2 = prev_w;
            prev_w = w;
            slot_stb_o = 1'b1;
         end
         link_clk_o = rise_i;
         #40;
         link_clk_o = !rise_i;
         slot_stb_o = 1'b0;
         latch_n_o = 1'b1;
         #40;
      end
      chip_n_o = 1'b1;
      oe_n_o = 1'b1;
      addr_o = ~start;
   endtask
endmodule // sbr_host_model

// >>> sync_burst_read_configuration_bench.sv
// self-checking bench for the burst read engine
module sync_burst_read_configuration_bench
   import sbr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // array word is its address scrambled by this key
   localparam logic [15:0] MEM_KEY = 16'h5a3c;
   // rows: latency, polarity, hold, timing, edge, wrap and length per burst
   // rows keep latency minimums, held slots and no latency-2 early hold
   localparam logic [15:0] ROW_CFG [6] = '{16'h1cc9, 16'h2081, 16'h2ec2, 16'h31cb, 16'h3d87,
                                           16'h14c3};
   localparam logic [22:0] ROW_START [6] = '{23'hd, 23'he, 23'h3, 23'h2, 23'he, 23'h7};

   logic        clk_sys = 1'b0;   // system clock
   logic        srst = 1'b1;      // reset
   logic        rp_n = 1'b1;      // reset pulse pin
   logic        cfg_wr = 1'b0;    // config strobe
   logic [15:0] cfg_data = 16'h0; // config value
   logic [15:0] cfg_q, data, mem_data;
   logic [22:0] addr, mem_addr;
   logic        done, first_address_latch_sequence, lclk, latch_n, chip_n, oe_n, data_oe, rw_o, rw_oe, rw_pin, stb;
   logic        drv_low = 1'b0;   // host pulls ready pin low
   logic        rise = 1'b1;
   logic        pol = 1'b1;
   logic        early = 1'b0;
   logic        two = 1'b0;       // two-edge slots
   logic [16:0] slot;
   logic [16:0] exp_q[$];         // expected slots in order
   int          err_total = 0;
   int          num_checks = 0;
   int          first_address_latch_sequence_cnt = 0;

   // array answers at once; pin has a pull-up
   assign mem_data = mem_addr[15:0] ^ MEM_KEY;
   assign rw_pin = rw_oe ? rw_o : !drv_low;

   sbr_burst_ctrl u_dut (
      .clk_sys_i(clk_sys), .srst_i(srst), .link_clk_i(lclk), .latch_n_i(latch_n),
      .chip_n_i(chip_n), .oe_n_i(oe_n), .reset_pulse_pin_n_i(rp_n), .addr_i(addr),
      .data_o(data), .data_oe_o(data_oe), .rdy_wait_i(rw_pin), .rdy_wait_o(rw_o),
      .rdy_wait_oe_o(rw_oe), .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_data), .cfg_o(cfg_q),
      .init_done_o(done), .first_address_latch_sequence_restart_o(first_address_latch_sequence), .mem_addr_o(mem_addr), .mem_data_i(mem_data)
   );
   sbr_host_model u_host (
      .link_clk_o(lclk), .latch_n_o(latch_n), .chip_n_o(chip_n), .oe_n_o(oe_n),
      .addr_o(addr), .data_i(data), .rdy_wait_i(rw_pin), .rise_i(rise), .pol_i(pol),
      .early_i(early), .two_i(two), .slot_stb_o(stb), .slot_o(slot)
   );

   // 100 MHz system clock
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // step n clocks, landing just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wait_init();
      for (int i = 0; i < 100 && done !== 1'b1; i++) tick(1);
      check("init_done", 17'h1, {16'h0, done});
   endtask

   task automatic cfg_write(input logic [15:0] v);
      cfg_data = v;
      cfg_wr = 1'b1;
      tick(1);
      cfg_wr = 1'b0;
      tick(1);
      check("cfg", {1'b0, v | 16'h0080}, {1'b0, cfg_q});
   endtask

   // expected slot, doubled when the word is held two cycles
   function automatic void note(input logic w, input logic [22:0] a, input logic two,
                                inout int k);
      repeat (two ? 2 : 1)
      begin
         exp_q.push_back(w ? 17'h10000 : {1'b0, a[15:0] ^ MEM_KEY});
         k++;
      end
   endfunction

   // program a row, predict its slots, let the host run it
   task automatic run(input logic [15:0] c, input logic [22:0] s, input int cont_n);
      int sz, k;
      logic [22:0] a;
      logic wrap, hit;
      sz = (c[2:0] == 3'h1) ? 4 : (c[2:0] == 3'h2) ? 8 : (c[2:0] == 3'h3) ? 16 : 0;
      wrap = !c[3] && sz != 0;
      hit = 1'b0;
      k = 0;
      cfg_write(c);
      rise = c[6];
      pol = c[10];
      early = c[8];
      two = c[9];
      repeat (int'(c[13:11]) + int'(c[9])) note(1'b1, s, 1'b0, k);
      for (int i = 0; i < (sz == 0 ? cont_n : sz); i++)
      begin
         a = wrap ? ((s & ~23'(sz - 1)) | ((s + 23'(i)) & 23'(sz - 1))) : s + 23'(i);
         if (!wrap && i > 0 && a[3:0] == 4'h0 && !hit)
         begin
            hit = 1'b1;
            repeat (s[1:0]) note(1'b1, a, c[9], k);
         end
         note(1'b0, a, c[9], k);
      end
      if (sz != 0) note(1'b1, a, 1'b0, k);
      u_host.burst(s, k);
      tick(8);
      check("leftover", 17'h0, 17'(exp_q.size()));
   endtask

   // each sampled slot is matched against the oldest prediction
   always @(posedge stb)
      check("slot", exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff, slot);

   // count restart pulses
   always @(posedge clk_sys)
      if (first_address_latch_sequence === 1'b1) first_address_latch_sequence_cnt++;

   initial
   begin
      logic [31:0] r;
      r = $urandom(60151);
      repeat (4) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      check("cfg_reset", 17'h03ddf, {1'b0, cfg_q});
      check("ready_low", 17'h1, {16'h0, rw_oe & !rw_o});
      wait_init();
      for (int i = 0; i < 3; i++) cfg_write(16'($urandom));
      for (int i = 0; i < 6; i++)
      begin
         r = $urandom;
         run(ROW_CFG[i], ROW_START[i] | {r[22:5], 5'h0}, (i == 4) ? 22 : 0);
      end
      rp_n = 1'b0;
      tick(8);
      check("cfg_reload", 17'h03ddf, {1'b0, cfg_q});
      rp_n = 1'b1;
      wait_init();
      tick(2);
      check("pin_free", 17'h0, {16'h0, rw_oe});
      drv_low = 1'b1;
      tick(6);
      drv_low = 1'b0;
      tick(12);
      check("restart", 17'h1, 17'(first_address_latch_sequence_cnt));
      wrap_up();
   end

   // cut a hang short
   initial
   begin
      #200000;
      err_total++;
      wrap_up();
   end
endmodule // sync_burst_read_configuration_bench
